/* core/cmcc_pkg.sv */
/*
  Constants, encodings and types shared by the conversion mode and
  calibration controller.
  Assumes a 24-bit result path, four input channels and an 8-bit status word.
*/
package cmcc_pkg;

  // Widths
  localparam int unsigned CH_COUNT = 4;
  localparam int unsigned CH_W = 2;
  localparam int unsigned DATA_W = 24;
  localparam int unsigned STATUS_W = 8;
  localparam int unsigned WORD_W = 32;

  // Mode field encodings, three bits wide
  localparam logic [2:0] MODE_CONTINUOUS = 3'h0;
  localparam logic [2:0] MODE_SINGLE = 3'h1;
  localparam logic [2:0] MODE_STANDBY = 3'h2;
  localparam logic [2:0] MODE_POWERDOWN = 3'h3;
  localparam logic [2:0] MODE_CAL_INT_ZERO = 3'h4;
  localparam logic [2:0] MODE_CAL_SYS_ZERO = 3'h6;
  localparam logic [2:0] MODE_CAL_SYS_FULL = 3'h7;

  // Clock source field value that selects the internal oscillator
  localparam logic [1:0] CLK_SRC_INTERNAL = 2'h0;

  // Calibration register defaults and scaling constants
  localparam logic [23:0] OFFSET_DEFAULT = 24'h800000;
  localparam logic [23:0] GAIN_NOMINAL = 24'h555555;
  localparam logic [23:0] CODE_MID = 24'h800000;
  localparam logic [23:0] CODE_MAX = 24'hFFFFFF;
  localparam logic [23:0] FULL_SCALE_TARGET = 24'h7FFFFF;
  localparam int unsigned GAIN_SHIFT_BIPOLAR = 22;
  localparam int unsigned GAIN_SHIFT_UNIPOLAR = 21;

  // Status word layout
  localparam int unsigned STATUS_RDY_BIT = 7;
  localparam int unsigned STATUS_CH_LSB = 0;

  // Serial side counts
  localparam logic [6:0] WAKE_SCLKS = 7'h40;
  localparam logic [5:0] READ_LEN_PLAIN = 6'h18;
  localparam logic [5:0] READ_LEN_STATUS = 6'h20;

  // Controller states
  typedef enum logic [1:0] {
    ST_STANDBY,
    ST_CONVERT,
    ST_CALIBRATE,
    ST_POWERDOWN
  } cmcc_state_e;

endpackage

/* core/cmcc_ctrl.sv */
/*
  Conversion mode and calibration controller of a multichannel sigma-delta
  converter: single conversion sequencing, standby and power-down, three
  calibration modes with result scaling, and the serial-side logic that
  shifts out results and detects the 64-clock interface reset.
  Assumes a digital filter on i_clock that returns one raw 24-bit two's
  complement sample per start pulse, and a host that drives the serial pins.
*/
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Single conversion mode converts once, then drops to standby by itself.
// - Full read of a result drives ready pin high; rereads stay possible.
// - Several channels enabled: each converted once in order, result overwritten, then standby.
// - Conversion start drives ready pin high; low once result valid and select low.
// - With append-status set, each read also shifts out status; low bits give channel.
// - Standby keeps regulators and registers; reference and crystal kept if chosen.
// - Reference power bit low turns internal reference off in standby.
// - Clock source field at internal oscillator stops the clock in standby.
// - Power-down switches everything off, loses registers, floats general-purpose outputs.
// - Power-down only accepted from standby; host selects standby first.
// - 64 serial clocks with select low and input high reset and wake.
// - Three calibrations per setup: internal zero, system zero, system full scale.
// - Calibration needs exactly one channel; every result is scaled by calibration registers.
// - Offset register defaults to 0x800000, gain register nominal 0x555555.
// - Scaled result formula; unipolar doubles, bipolar adds 0x800000.
// - Calibration starts on mode write; ready pin and status ready bit go high.
// - Calibration end updates register, clears ready bit, pin low, back to standby.
// - Internal offset calibration ties both modulator inputs to the negative input.
// - Calibration lasts one filter settling time; calibration registers locked meanwhile.
module cmcc_ctrl (
  // Master clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Serial pins, clocked by the host's serial clock
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_din,
  output logic o_dout_rdy_n,
  output logic o_dout_oe,
  // Mode and configuration
  input wire logic i_mode_wr,
  input wire logic [2:0] i_mode,
  input wire logic [3:0] i_ch_enable,
  input wire logic i_unipolar,
  input wire logic i_append_status,
  input wire logic i_ref_enable,
  input wire logic [1:0] i_clock_source_field,
  // Calibration register access
  input wire logic i_cal_wr,
  input wire logic i_cal_sel_gain,
  input wire logic [1:0] i_cal_ch,
  input wire logic [23:0] i_cal_wdata,
  output logic [23:0] o_cal_rdata,
  // Digital filter
  output logic o_filter_start,
  output logic [1:0] o_filter_channel,
  output logic o_filter_zero_input,
  input wire logic i_filter_done,
  input wire logic [23:0] i_filter_data,
  // Result and status
  output logic [23:0] o_result,
  output logic [7:0] o_status,
  output logic [1:0] o_state,
  // Power controls
  output logic o_core_power,
  output logic o_ldo_on,
  output logic o_ref_power,
  output logic o_clock_run,
  output logic o_gpio_hiz
);

  // Scale a raw sample with one channel's offset and gain
  function automatic logic [23:0] scale_sample(
    input logic [23:0] raw,
    input logic [23:0] off,
    input logic [23:0] gain,
    input logic uni
  );
    logic signed [26:0] diff;
    logic signed [51:0] prod;
    logic signed [51:0] res;
    diff = $signed({{3{raw[23]}}, raw}) -
           ($signed({3'h0, off}) - $signed({3'h0, cmcc_pkg::CODE_MID}));
    prod = diff * $signed({1'b0, gain});
    if (uni) begin
      res = prod >>> cmcc_pkg::GAIN_SHIFT_UNIPOLAR; // Doubling folded into the shift
    end else begin
      res = (prod >>> cmcc_pkg::GAIN_SHIFT_BIPOLAR) +
            $signed({28'h0, cmcc_pkg::CODE_MID});
    end
    // Saturate rather than wrap, an overrange input must not fold back
    if (res < 0) begin
      scale_sample = 24'h0;
    end else if (res > $signed({28'h0, cmcc_pkg::CODE_MAX})) begin
      scale_sample = cmcc_pkg::CODE_MAX;
    end else begin
      scale_sample = res[23:0];
    end
  endfunction

  // Lowest enabled channel above a given one; bit 2 set when none is found
  function automatic logic [2:0] next_channel(
    input logic [3:0] en,
    input logic [2:0] above
  );
    logic [2:0] found;
    found = 3'h4;
    for (int i = cmcc_pkg::CH_COUNT - 1; i >= 0; i--) begin
      if (en[i] && (3'(i) > above || above == 3'h7)) begin
        found = 3'(i);
      end
    end
    next_channel = found;
  endfunction

  // Main-domain state
  cmcc_pkg::cmcc_state_e state_ff;
  logic [2:0] cal_mode_ff;
  logic [1:0] chan_ff;
  logic filter_start_ff;
  logic [23:0] result_ff;
  logic [1:0] result_ch_ff;
  logic status_rdy_n_ff;
  logic pin_rdy_n_ff;
  logic [31:0] read_word_ff;
  logic read_len32_ff;
  logic [23:0] offset_ff [cmcc_pkg::CH_COUNT];
  logic [23:0] gain_ff [cmcc_pkg::CH_COUNT];
  logic [23:0] cal_rdata_ff;
  logic ref_power_ff;
  logic clock_run_ff;

  // Crossing flops for serial-side events
  logic [1:0] wake_sync_ff;
  logic wake_seen_ff;
  logic [1:0] done_sync_ff;
  logic done_seen_ff;

  // Serial-side flops
  logic [6:0] ones_cnt_ff;
  logic [5:0] bit_cnt_ff;
  logic [31:0] shift_ff;
  logic [5:0] len_ff;
  logic loaded_ff;
  logic wake_tgl_ff;
  logic done_tgl_ff;

  logic wake_evt;
  logic read_done_evt;
  logic one_channel;
  logic [2:0] first_ch;
  logic [2:0] after_ch;
  logic [1:0] only_ch;
  logic [23:0] scaled;
  logic signed [26:0] cal_diff;
  logic [45:0] gain_quot;
  logic [23:0] gain_new;
  logic cal_done;
  logic start_single;
  logic start_cal;
  logic frame_rst_n;

  // Event edges seen only on the second synchroniser stage
  assign wake_evt = wake_sync_ff[1] ^ wake_seen_ff;
  assign read_done_evt = done_sync_ff[1] ^ done_seen_ff;

  // Channel selection helpers
  assign one_channel = ($countones(i_ch_enable) == 1);
  assign first_ch = next_channel(i_ch_enable, 3'h7);
  assign after_ch = next_channel(i_ch_enable, {1'b0, chan_ff});
  assign only_ch = first_ch[1:0];
  assign start_single = i_mode_wr && i_mode == cmcc_pkg::MODE_SINGLE && !first_ch[2];
  assign start_cal = i_mode_wr && one_channel &&
                     (i_mode == cmcc_pkg::MODE_CAL_INT_ZERO ||
                      i_mode == cmcc_pkg::MODE_CAL_SYS_ZERO ||
                      i_mode == cmcc_pkg::MODE_CAL_SYS_FULL);
  assign cal_done = state_ff == cmcc_pkg::ST_CALIBRATE && i_filter_done;

  // Every conversion result passes through the channel's calibration
  assign scaled = scale_sample(i_filter_data, offset_ff[chan_ff], gain_ff[chan_ff],
                               i_unipolar);

  // Full-scale gain: what maps the measured span onto the full-scale code
  assign cal_diff = $signed({{3{i_filter_data[23]}}, i_filter_data}) -
                    ($signed({3'h0, offset_ff[chan_ff]}) -
                     $signed({3'h0, cmcc_pkg::CODE_MID}));
  assign gain_quot = (cal_diff > 0) ?
                     {cmcc_pkg::FULL_SCALE_TARGET, 22'h0} / {19'h0, cal_diff} : 46'h0;
  assign gain_new = (cal_diff <= 0) ? gain_ff[chan_ff] :
                    (gain_quot[45:24] != 22'h0) ? cmcc_pkg::CODE_MAX : gain_quot[23:0];

  // Mode sequencing
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= cmcc_pkg::ST_STANDBY;
      cal_mode_ff <= cmcc_pkg::MODE_STANDBY;
      chan_ff <= 2'h0;
      filter_start_ff <= 1'b0;
    end else begin
      filter_start_ff <= 1'b0;
      if (wake_evt) begin
        // Interface reset wakes from power-down and returns to standby
        state_ff <= cmcc_pkg::ST_STANDBY;
        cal_mode_ff <= cmcc_pkg::MODE_STANDBY;
      end else begin
        case (state_ff)
          cmcc_pkg::ST_STANDBY: begin
            if (start_single) begin
              state_ff <= cmcc_pkg::ST_CONVERT;
              chan_ff <= first_ch[1:0]; // Lowest enabled channel first
              filter_start_ff <= 1'b1;
            end else if (start_cal) begin
              state_ff <= cmcc_pkg::ST_CALIBRATE;
              cal_mode_ff <= i_mode;
              chan_ff <= only_ch;
              filter_start_ff <= 1'b1;
            end else if (i_mode_wr && i_mode == cmcc_pkg::MODE_POWERDOWN) begin
              state_ff <= cmcc_pkg::ST_POWERDOWN; // Only reachable from standby
            end
          end
          cmcc_pkg::ST_CONVERT: begin
            if (i_mode_wr && i_mode == cmcc_pkg::MODE_STANDBY) begin
              state_ff <= cmcc_pkg::ST_STANDBY;
            end else if (i_filter_done) begin
              if (after_ch[2]) begin
                state_ff <= cmcc_pkg::ST_STANDBY; // Last channel done
              end else begin
                chan_ff <= after_ch[1:0]; // Next channel while host reads
                filter_start_ff <= 1'b1;
              end
            end
          end
          cmcc_pkg::ST_CALIBRATE: begin
            if (i_mode_wr && i_mode == cmcc_pkg::MODE_STANDBY) begin
              state_ff <= cmcc_pkg::ST_STANDBY;
            end else if (cal_done) begin
              state_ff <= cmcc_pkg::ST_STANDBY;
            end
          end
          cmcc_pkg::ST_POWERDOWN: begin
            state_ff <= cmcc_pkg::ST_POWERDOWN; // Only the interface reset leaves
          end
          default: begin
            state_ff <= cmcc_pkg::ST_STANDBY;
          end
        endcase
      end
    end
  end

  // Result register and its channel tag
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      result_ff <= 24'h0;
      result_ch_ff <= 2'h0;
    end else if (wake_evt) begin
      result_ff <= 24'h0;
      result_ch_ff <= 2'h0;
    end else if (state_ff == cmcc_pkg::ST_CONVERT && i_filter_done) begin
      result_ff <= scaled; // Overwrites the previous channel's word
      result_ch_ff <= chan_ff;
    end
  end

  // Status ready bit: high on start, low when a result or calibration lands
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status_rdy_n_ff <= 1'b1;
    end else if (wake_evt) begin
      status_rdy_n_ff <= 1'b1;
    end else if (i_filter_done && state_ff != cmcc_pkg::ST_STANDBY &&
                 state_ff != cmcc_pkg::ST_POWERDOWN) begin
      status_rdy_n_ff <= 1'b0;
    end else if (start_single || (state_ff == cmcc_pkg::ST_STANDBY && start_cal)) begin
      status_rdy_n_ff <= 1'b1;
    end
  end

  // Ready level on the data pin; a new result beats a read that ends alongside
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_rdy_n_ff <= 1'b1;
    end else if (wake_evt) begin
      pin_rdy_n_ff <= 1'b1;
    end else if (i_filter_done && state_ff != cmcc_pkg::ST_STANDBY &&
                 state_ff != cmcc_pkg::ST_POWERDOWN) begin
      pin_rdy_n_ff <= 1'b0;
    end else if (state_ff == cmcc_pkg::ST_STANDBY && (start_single || start_cal)) begin
      pin_rdy_n_ff <= 1'b1;
    end else if (read_done_evt) begin
      pin_rdy_n_ff <= 1'b1; // Word stays for rereads
    end
  end

  // Word offered to the serial side, reloaded every cycle from the result and status
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      read_word_ff <= 32'h0;
      read_len32_ff <= 1'b0;
    end else begin
      read_len32_ff <= i_append_status;
      if (i_append_status) begin
        read_word_ff <= {result_ff, o_status}; // Status follows the data
      end else begin
        read_word_ff <= {result_ff, 8'h0};
      end
    end
  end

  // Per-channel offset and gain registers
  for (genvar g = 0; g < cmcc_pkg::CH_COUNT; g++) begin : g_cal
    always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
        offset_ff[g] <= cmcc_pkg::OFFSET_DEFAULT;
        gain_ff[g] <= cmcc_pkg::GAIN_NOMINAL;
      end else if (wake_evt) begin
        offset_ff[g] <= cmcc_pkg::OFFSET_DEFAULT; // Contents lost across reset
        gain_ff[g] <= cmcc_pkg::GAIN_NOMINAL;
      end else if (cal_done && chan_ff == 2'(g)) begin
        if (cal_mode_ff == cmcc_pkg::MODE_CAL_SYS_FULL) begin
          gain_ff[g] <= gain_new;
        end else begin
          offset_ff[g] <= i_filter_data + cmcc_pkg::CODE_MID;
        end
      end else if (i_cal_wr && i_cal_ch == 2'(g) &&
                   state_ff != cmcc_pkg::ST_CALIBRATE &&
                   state_ff != cmcc_pkg::ST_POWERDOWN) begin
        // Host access is locked out while a calibration runs
        if (i_cal_sel_gain) begin
          gain_ff[g] <= i_cal_wdata;
        end else begin
          offset_ff[g] <= i_cal_wdata;
        end
      end
    end
  end

  // Calibration readback, zero while a calibration runs
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cal_rdata_ff <= 24'h0;
    end else if (state_ff == cmcc_pkg::ST_CALIBRATE) begin
      cal_rdata_ff <= 24'h0;
    end else begin
      cal_rdata_ff <= i_cal_sel_gain ? gain_ff[i_cal_ch] : offset_ff[i_cal_ch];
    end
  end

  // Power controls, registered from the mode
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ref_power_ff <= 1'b0;
      clock_run_ff <= 1'b0;
    end else if (state_ff == cmcc_pkg::ST_POWERDOWN) begin
      ref_power_ff <= 1'b0;
      clock_run_ff <= 1'b0;
    end else if (state_ff == cmcc_pkg::ST_STANDBY) begin
      ref_power_ff <= i_ref_enable;
      clock_run_ff <= i_clock_source_field != cmcc_pkg::CLK_SRC_INTERNAL;
    end else begin
      ref_power_ff <= 1'b1;
      clock_run_ff <= 1'b1;
    end
  end

  // Bring serial-side toggles into the master clock domain
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wake_sync_ff <= 2'h0;
      wake_seen_ff <= 1'b0;
      done_sync_ff <= 2'h0;
      done_seen_ff <= 1'b0;
    end else begin
      wake_sync_ff <= {wake_sync_ff[0], wake_tgl_ff};
      wake_seen_ff <= wake_sync_ff[1];
      done_sync_ff <= {done_sync_ff[0], done_tgl_ff};
      done_seen_ff <= done_sync_ff[1];
    end
  end

  // Serial-side counters end with the frame, since the serial clock stops
  assign frame_rst_n = i_rst_n & ~i_cs_n;

  // Wake detector and read shifter on the serial clock
  always_ff @(posedge i_sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      ones_cnt_ff <= 7'h0;
      bit_cnt_ff <= 6'h0;
      shift_ff <= 32'h0;
      len_ff <= cmcc_pkg::READ_LEN_PLAIN;
      loaded_ff <= 1'b0;
    end else begin
      if (!i_din) begin
        ones_cnt_ff <= 7'h0;
      end else if (ones_cnt_ff != cmcc_pkg::WAKE_SCLKS) begin
        ones_cnt_ff <= ones_cnt_ff + 7'h1;
      end
      if (!loaded_ff) begin
        // Word sampled once per frame; host keeps clear of updates
        shift_ff <= read_word_ff;
        len_ff <= read_len32_ff ? cmcc_pkg::READ_LEN_STATUS : cmcc_pkg::READ_LEN_PLAIN;
        loaded_ff <= 1'b1;
        bit_cnt_ff <= 6'h1;
      end else if (bit_cnt_ff != len_ff) begin
        shift_ff <= {shift_ff[30:0], 1'b0};
        bit_cnt_ff <= bit_cnt_ff + 6'h1;
      end
    end
  end

  // Event toggles survive frame end so the crossing never sees a false edge
  always_ff @(posedge i_sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wake_tgl_ff <= 1'b0;
      done_tgl_ff <= 1'b0;
    end else begin
      if (i_din && ones_cnt_ff == cmcc_pkg::WAKE_SCLKS - 7'h1) begin
        wake_tgl_ff <= ~wake_tgl_ff; // 64th high bit with select low
      end
      if (loaded_ff && bit_cnt_ff == len_ff - 6'h1) begin
        done_tgl_ff <= ~done_tgl_ff; // Last bit of the word shifted
      end
    end
  end

  // Pin: data bit while a frame shifts, otherwise the ready level
  assign o_dout_rdy_n = loaded_ff ? shift_ff[31] : pin_rdy_n_ff;
  assign o_dout_oe = ~i_cs_n; // Ready only shows while selected

  // Filter and status outputs
  assign o_filter_start = filter_start_ff;
  assign o_filter_channel = chan_ff;
  assign o_filter_zero_input = state_ff == cmcc_pkg::ST_CALIBRATE &&
                               cal_mode_ff == cmcc_pkg::MODE_CAL_INT_ZERO;
  assign o_result = result_ff;
  assign o_status = {status_rdy_n_ff, 5'h0, result_ch_ff}; // Channel in low bits
  assign o_state = state_ff;
  assign o_cal_rdata = cal_rdata_ff;

  // Power outputs; regulators drop only in power-down
  assign o_core_power = state_ff == cmcc_pkg::ST_CONVERT ||
                        state_ff == cmcc_pkg::ST_CALIBRATE;
  assign o_ldo_on = state_ff != cmcc_pkg::ST_POWERDOWN;
  assign o_gpio_hiz = state_ff == cmcc_pkg::ST_POWERDOWN;
  assign o_ref_power = ref_power_ff;
  assign o_clock_run = clock_run_ff;

endmodule

`default_nettype wire

/* sim/cmcc_ctrl_sva.sv */
/* Checker for cmcc_ctrl ports on the master clock.
   Assumes the bind below. */
`timescale 1ns/1ps
`default_nettype none
module cmcc_ctrl_sva (
  // Clock, reset, inputs
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_cs_n,
  input wire logic i_mode_wr,
  input wire logic [2:0] i_mode,
  input wire logic [3:0] i_ch_enable,
  input wire logic i_ref_enable,
  input wire logic [1:0] i_clock_source_field,
  input wire logic i_filter_done,
  // Outputs watched
  input wire logic o_dout_oe,
  input wire logic o_filter_start,
  input wire logic [1:0] o_filter_channel,
  input wire logic o_filter_zero_input,
  input wire logic [7:0] o_status,
  input wire logic [1:0] o_state,
  input wire logic o_core_power,
  input wire logic o_ldo_on,
  input wire logic o_ref_power,
  input wire logic o_clock_run,
  input wire logic o_gpio_hiz
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // State decodes; a mode write only starts work from standby
  wire idle = o_state == 2'h0;
  wire busy = o_state == 2'h1 || o_state == 2'h2;
  wire go = i_mode_wr && idle;
  wire last = (i_ch_enable >> o_filter_channel) == 4'h1;
  property p_single_go;
    go && i_mode == cmcc_pkg::MODE_SINGLE && |i_ch_enable
      |=> o_state == 2'h1 && o_filter_start && o_status[7];
  endproperty
  a_single_go: assert property (p_single_go) else $error("single start");
  property p_done_ch;
    o_state == 2'h1 && i_filter_done |=> o_status[1:0] == $past(o_filter_channel) && !o_status[7];
  endproperty
  a_done_ch: assert property (p_done_ch) else $error("status channel");
  property p_last;
    o_state == 2'h1 && i_filter_done && last |=> idle;
  endproperty
  a_last: assert property (p_last) else $error("no standby after last");
  property p_pd_gate;
    i_mode_wr && i_mode == cmcc_pkg::MODE_POWERDOWN && busy |=> o_state != 2'h3;
  endproperty
  a_pd_gate: assert property (p_pd_gate) else $error("power-down taken");
  // Supplies follow the state with no lag
  property p_power;
    o_ldo_on == (o_state != 2'h3) && o_gpio_hiz == (o_state == 2'h3) && o_core_power == busy;
  endproperty
  a_power: assert property (p_power) else $error("supply levels");
  // Skip the first edge after reset
  property p_ref;
    idle && $past(idle) && $past(i_rst_n) && $stable(i_ref_enable) |-> o_ref_power == i_ref_enable;
  endproperty
  a_ref: assert property (p_ref) else $error("reference power");
  property p_clk;
    idle && $past(idle) && $past(i_rst_n) && $stable(i_clock_source_field)
      |-> o_clock_run == (i_clock_source_field != cmcc_pkg::CLK_SRC_INTERNAL);
  endproperty
  a_clk: assert property (p_clk) else $error("clock run");
  property p_cal_go;
    go && i_mode == cmcc_pkg::MODE_CAL_INT_ZERO && $onehot(i_ch_enable)
      |=> o_state == 2'h2 && o_filter_zero_input && o_status[7];
  endproperty
  a_cal_go: assert property (p_cal_go) else $error("calibration start");
  property p_cal_end;
    o_state == 2'h2 && i_filter_done |=> idle && !o_status[7];
  endproperty
  a_cal_end: assert property (p_cal_end) else $error("calibration end");
  property p_oe;
    o_dout_oe == !i_cs_n;
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable");
  // Main scenarios reached
  c_next: cover property (o_state == 2'h1 && i_filter_done && !last ##1 o_filter_start);
  c_cal: cover property (o_state == 2'h2 && i_filter_done);
  c_pd: cover property (o_state == 2'h3);
endmodule
bind cmcc_ctrl cmcc_ctrl_sva u_sva (.*);
`default_nettype wire

/* sim/cmcc_host_model.sv */
/* Behavioural host on the serial pins: frame reads, ready peeks, wake reset.
   Assumes the caller spaces its requests; serial clock idles low between frames. */
`timescale 1ns/1ps
`default_nettype none
module cmcc_host_model (
  // Serial pins
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_din,
  input wire logic i_dout_rdy_n
);
  // 125 ns serial period, phase unrelated to the master clock
  localparam realtime HALF = 62.5;
  initial begin
    o_sclk = 1'h0;
    o_cs_n = 1'h1;
    o_din = 1'h0;
  end
  // One rising edge; the bit is taken at the falling edge
  task pulse(output logic b);
    o_sclk = 1'h1;
    #(HALF);
    o_sclk = 1'h0;
    b = i_dout_rdy_n;
    #(HALF);
  endtask
  // Whole frame, MSB first; caller reads before the next result lands
  task read(input int len, output logic [31:0] w);
    logic b;
    w = 32'h0;
    o_cs_n = 1'h0;
    #(HALF);
    for (int k = 0; k < len; k++) begin
      pulse(b);
      w = {w[30:0], b};
    end
    o_cs_n = 1'h1;
    #(HALF);
  endtask
  // Ready level, select low with no edge
  task rdy(output logic r);
    o_cs_n = 1'h0;
    #(HALF);
    r = i_dout_rdy_n;
    o_cs_n = 1'h1;
    #(HALF);
  endtask
  // Interface reset
  task wake();
    logic b;
    o_cs_n = 1'h0;
    o_din = 1'h1;
    #(HALF);
    repeat (64) pulse(b);
    o_din = 1'h0;
    o_cs_n = 1'h1;
    #(HALF);
  endtask
endmodule
`default_nettype wire

/* sim/tb_cmcc_ctrl.sv */
/* Bench for cmcc_ctrl: modes, calibration, power.
   Assumes the host model and checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_cmcc_ctrl;
  // Stimulus, changed at falling edges
  logic clk = 1'h0, rst_n = 1'h0, mwr = 1'h0, uni = 1'h0, app = 1'h0;
  logic refe = 1'h0, cwr = 1'h0, cg = 1'h0, fd = 1'h0, r;
  logic [1:0] csrc = 2'h0, cch = 2'h0;
  logic [2:0] md = 3'h2;
  logic [3:0] en = 4'h0;
  logic [23:0] cd = 24'h0, fdat = 24'h0;
  logic [31:0] w;
  wire sclk, csn, din, pin, oe, fst, fz, cpw, ldo, rpw, crun, hiz;
  wire [1:0] fch, st;
  wire [7:0] sts;
  wire [23:0] crd, res;
  int err_count = 0, comparisons = 0, cyc = 0;
  always #2 clk = ~clk;
  cmcc_ctrl dut (.i_clock(clk), .i_rst_n(rst_n), .i_sclk(sclk), .i_cs_n(csn), .i_din(din),
    .o_dout_rdy_n(pin), .o_dout_oe(oe), .i_mode_wr(mwr), .i_mode(md), .i_ch_enable(en),
    .i_unipolar(uni), .i_append_status(app), .i_ref_enable(refe),
    .i_clock_source_field(csrc), .i_cal_wr(cwr), .i_cal_sel_gain(cg), .i_cal_ch(cch),
    .i_cal_wdata(cd), .o_cal_rdata(crd), .o_filter_start(fst), .o_filter_channel(fch),
    .o_filter_zero_input(fz), .i_filter_done(fd), .i_filter_data(fdat), .o_result(res),
    .o_status(sts), .o_state(st), .o_core_power(cpw), .o_ldo_on(ldo), .o_ref_power(rpw),
    .o_clock_run(crun), .o_gpio_hiz(hiz));
  cmcc_host_model host (.o_sclk(sclk), .o_cs_n(csn), .o_din(din), .i_dout_rdy_n(pin));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_sim();
    if (err_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Strobes drop for a full cycle
  task mode(input logic [2:0] m);
    md = m;
    mwr = 1'h1;
    @(negedge clk);
    mwr = 1'h0;
    @(negedge clk);
  endtask
  task conv(input logic [23:0] raw);
    fdat = raw;
    fd = 1'h1;
    @(negedge clk);
    fd = 1'h0;
    @(negedge clk);
  endtask
  task calw(input logic g, input logic [1:0] ch, input logic [23:0] d);
    cg = g;
    cch = ch;
    cd = d;
    cwr = 1'h1;
    @(negedge clk);
    cwr = 1'h0;
    @(negedge clk);
  endtask
  // Readback lags the selects by one cycle
  task calr(input logic g, input logic [1:0] ch, input logic [23:0] e);
    cg = g;
    cch = ch;
    repeat (2) @(negedge clk);
    chk(32'(crd), 32'(e));
  endtask
  task t_defaults();
    chk(32'({sts, st}), 32'h200);
    for (int c = 0; c < 4; c++) begin
      calr(1'h0, 2'(c), 24'h800000);
      calr(1'h1, 2'(c), 24'h555555);
    end
    chk(32'({rpw, crun}), 32'h0);
    refe = 1'h1;
    csrc = 2'h1;
    repeat (2) @(negedge clk);
    chk(32'({rpw, crun, ldo, hiz}), 32'hE);
  endtask
  task t_single();
    calw(1'h1, 2'h0, 24'h400000);
    calw(1'h1, 2'h2, 24'h400000);
    en = 4'h5;
    app = 1'h1;
    mode(cmcc_pkg::MODE_SINGLE);
    host.rdy(r);
    @(negedge clk);
    chk(32'({r, fch, st}), 32'h11);
    conv(24'h000123);
    chk(32'(res), 32'h800123);
    host.rdy(r);
    chk(32'(r), 32'h0);
    host.read(32, w);
    chk(w, 32'h80012300);
    host.read(32, w);
    chk(w, 32'h80012300);
    host.rdy(r);
    @(negedge clk);
    chk(32'({r, fch, st}), 32'h19);
    conv(24'hFFFF00);
    chk({res, sts}, 32'h7FFF0002);
    chk(32'(st), 32'h0);
    en = 4'h1;
    app = 1'h0;
    uni = 1'h1;
    mode(cmcc_pkg::MODE_SINGLE);
    conv(24'h000100);
    host.read(24, w);
    chk(w, 32'h000200);
    chk(32'(st), 32'h0);
    uni = 1'h0;
  endtask
  task t_cal();
    en = 4'h3;
    mode(cmcc_pkg::MODE_CAL_INT_ZERO);
    chk(32'(st), 32'h0);
    en = 4'h1;
    mode(cmcc_pkg::MODE_CAL_INT_ZERO);
    chk(32'({st, fz}), 32'h5);
    calr(1'h0, 2'h0, 24'h000000);
    conv(24'h000010);
    calr(1'h0, 2'h0, 24'h800010);
    mode(cmcc_pkg::MODE_CAL_SYS_ZERO);
    conv(24'h000020);
    calr(1'h0, 2'h0, 24'h800020);
    // Offset settled before the full-scale step
    mode(cmcc_pkg::MODE_CAL_SYS_FULL);
    conv(24'h400020);
    calr(1'h1, 2'h0, 24'h7FFFFF);
    chk(32'({sts[7], st}), 32'h0);
    mode(cmcc_pkg::MODE_SINGLE);
    conv(24'h400020);
    chk(32'(res), 32'hFFFFFF);
  endtask
  task t_power();
    mode(cmcc_pkg::MODE_SINGLE);
    mode(cmcc_pkg::MODE_POWERDOWN);
    chk(32'(st), 32'h1);
    mode(cmcc_pkg::MODE_STANDBY);
    mode(cmcc_pkg::MODE_POWERDOWN);
    chk(32'({st, ldo, hiz}), 32'hD);
    mode(cmcc_pkg::MODE_SINGLE);
    chk(32'(st), 32'h3);
    // No serial command follows the wake
    host.wake();
    repeat (8) @(negedge clk);
    chk({res, 6'h0, st}, 32'h0);
    calr(1'h1, 2'h0, 24'h555555);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_n = 1'h1;
    @(negedge clk);
    t_defaults();
    t_single();
    t_cal();
    t_power();
    end_sim();
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      end_sim();
    end
  end
endmodule
`default_nettype wire
